// ===== hdl/run_stop_pkg.sv
// run/stop sequencer package: register map, field layout, reset values, timing, types
package run_stop_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] CTRL_OFS   = 8'h00;  // run source and stop method
  localparam logic [7:0] MFI_OFS    = 8'h04;  // multi-function input selections
  localparam logic [7:0] INIT_OFS   = 8'h08;  // init mode command
  localparam logic [7:0] BRAKE_OFS  = 8'h0C;  // zero speed, brake current, brake time
  localparam logic [7:0] LIMIT_OFS  = 8'h10;  // lower output frequency limit
  localparam logic [7:0] TIMES_OFS  = 8'h14;  // baseblock time and decel time
  localparam logic [7:0] STATUS_OFS = 8'h18;  // read-only state

  // field positions
  localparam int SRC_LSB   = 0;   // run_source_select [1:0]
  localparam int STOP_LSB  = 2;   // stop_method_select [3:2]
  localparam int MFI_W     = 6;   // width of one input selection field
  localparam int ZSPD_LSB  = 0;   // zero_speed_level [7:0], 0.1 hz
  localparam int CUR_LSB   = 8;   // dc_brake_current [14:8], percent
  localparam int BTIME_LSB = 16;  // dc_brake_stop_time [25:16], 0.01 s
  localparam int OFF_LSB   = 0;   // min_output_off_time [7:0], 0.1 s
  localparam int DECEL_LSB = 16;  // decel_time_one [31:16], 0.1 s

  // reset values and setting limits
  localparam logic [1:0]  SRC_RST    = 2'h1;        // control terminals
  localparam logic [1:0]  STOP_RST   = 2'h0;        // decelerate
  localparam logic [29:0] MFI_RST    = 30'h61440C1; // fields 1,3,4,5,6: two-wire
  localparam logic [29:0] MFI_3WIRE  = 30'h61400C1; // fifth terminal field is zero
  localparam logic [15:0] INIT_3WIRE = 16'h0D02;    // init value 3330
  localparam logic [7:0]  ZSPD_RST   = 8'h05;       // 0.5 hz
  localparam logic [7:0]  ZSPD_MAX   = 8'h64;       // 10.0 hz
  localparam logic [6:0]  CUR_RST    = 7'h32;       // 50 percent
  localparam logic [6:0]  CUR_MAX    = 7'h64;       // 100 percent
  localparam logic [9:0]  BTIME_RST  = 10'h032;     // 0.50 s
  localparam logic [9:0]  BTIME_MAX  = 10'h3E8;     // 10.00 s
  localparam logic [15:0] LIMIT_RST  = 16'h0000;    // 0.0 hz
  localparam logic [7:0]  OFF_RST    = 8'h05;       // 0.5 s
  localparam logic [15:0] DECEL_RST  = 16'h0064;    // 10.0 s
  localparam logic [3:0]  DECI_TICKS = 4'hA;        // 10 ms ticks per 0.1 s

  // timing: all timers count 10 ms ticks
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS       = 10000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // run source and stopping method codes
  typedef enum logic [1:0] {
    SRC_PANEL = 2'b00, SRC_TERM = 2'b01, SRC_COMM = 2'b10, SRC_OPT = 2'b11
  } run_src_t;
  typedef enum logic [1:0] {
    STOP_DECEL = 2'b00, STOP_COAST = 2'b01, STOP_DCB = 2'b10, STOP_TIMER = 2'b11
  } stop_mode_t;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_RUN = 3'b001, ST_DECEL = 3'b010,
    ST_BRAKE = 3'b011, ST_BBWAIT = 3'b100, ST_LOCK = 3'b101
  } seq_state_t;

  // operator panel key presses (run, stop, fwd_rev are one-cycle; jog is a level)
  typedef struct packed {
    logic run;
    logic stop;
    logic jog;
    logic fwd_rev;
  } panel_keys_t;

  // run command from serial link or option card
  typedef struct packed {
    logic run;
    logic rev;
  } ext_cmd_t;

  // commands to the power stage
  typedef struct packed {
    logic       output_on;
    logic       reverse;
    logic       decel_req;
    logic       dc_brake;
    logic [6:0] brake_current;
  } drive_out_t;

endpackage

// ===== hdl/run_stop_sequencer.sv
// run/stop sequencer: run source select, 2/3-wire decode, stop methods, apb registers
module run_stop_sequencer #(
  parameter int TICK_CYCLES = run_stop_pkg::TICK_CYCLES  // clocks per 10 ms tick
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [6:0]                term_in,
  input  wire run_stop_pkg::panel_keys_t panel,
  input  wire run_stop_pkg::ext_cmd_t    comm_cmd,
  input  wire run_stop_pkg::ext_cmd_t    opt_cmd,
  input  wire logic [15:0]               out_freq,
  output run_stop_pkg::drive_out_t       drive
);

  // configuration registers
  logic [1:0]  run_source_select_r, run_source_select_nxt;
  logic [1:0]  stop_method_select_r, stop_method_select_nxt;
  logic [29:0] mfi_r, mfi_nxt;                           // five selection fields
  logic [7:0]  zero_speed_level_r, zero_speed_level_nxt;
  logic [6:0]  dc_brake_current_r, dc_brake_current_nxt;
  logic [9:0]  dc_brake_stop_time_r, dc_brake_stop_time_nxt;
  logic [15:0] lower_output_freq_limit_r, lower_output_freq_limit_nxt;
  logic [7:0]  min_output_off_time_r, min_output_off_time_nxt;
  logic [15:0] decel_time_one_r, decel_time_one_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pslverr_r, pslverr_nxt;
  // run command decode state
  logic        panel_run_r, panel_run_nxt;                // panel run latch
  logic        panel_rev_r, panel_rev_nxt;                // panel direction
  logic        wire3_run_r, wire3_run_nxt;                // three-wire self-hold
  // sequencer state
  run_stop_pkg::seq_state_t state_r, state_nxt;
  logic [19:0] timer_r, timer_nxt;                        // 10 ms ticks left
  logic [19:0] tick_cnt_r, tick_cnt_nxt;
  logic        dir_r, dir_nxt;                            // direction while running
  run_stop_pkg::drive_out_t drive_r, drive_nxt;
  // combinational helpers
  logic        wr_en, setup, mapped;
  logic        tick;
  logic [4:0]  dir_sel;                                   // field set to zero
  logic [4:0]  dir_hit;                                   // selected terminal is on
  logic        three_wire;
  logic        run_cmd, rev_cmd;
  logic [15:0] start_freq;                                // dc brake start level
  logic [19:0] off_ticks, decel_ticks, brake_ticks;

  assign pready  = 1'b1;                                  // no wait states
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign drive   = drive_r;
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite & mapped;
  assign mapped  = (paddr == run_stop_pkg::CTRL_OFS) || (paddr == run_stop_pkg::MFI_OFS)
                || (paddr == run_stop_pkg::INIT_OFS) || (paddr == run_stop_pkg::BRAKE_OFS)
                || (paddr == run_stop_pkg::LIMIT_OFS) || (paddr == run_stop_pkg::TIMES_OFS)
                || (paddr == run_stop_pkg::STATUS_OFS);

  // per input selection: zero makes that terminal the direction input
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_mfi
      assign dir_sel[gi] = (mfi_r[gi*run_stop_pkg::MFI_W +: run_stop_pkg::MFI_W] == 6'h00);
      assign dir_hit[gi] = dir_sel[gi] & term_in[gi+2];
    end
  endgenerate
  assign three_wire = |dir_sel;

  // brake starts at the higher of zero speed level and lower limit
  assign start_freq = ({8'h00, zero_speed_level_r} < lower_output_freq_limit_r)
                    ? lower_output_freq_limit_r : {8'h00, zero_speed_level_r};
  assign off_ticks   = 20'(min_output_off_time_r) * 20'(run_stop_pkg::DECI_TICKS);
  assign decel_ticks = 20'(decel_time_one_r) * 20'(run_stop_pkg::DECI_TICKS);
  assign brake_ticks = 20'(dc_brake_stop_time_r);
  assign tick        = (tick_cnt_r == 20'(TICK_CYCLES - 1));

  // register writes with range clamps, read data captured in the setup cycle
  always_comb begin
    run_source_select_nxt       = run_source_select_r;
    stop_method_select_nxt      = stop_method_select_r;
    mfi_nxt                     = mfi_r;
    zero_speed_level_nxt        = zero_speed_level_r;
    dc_brake_current_nxt        = dc_brake_current_r;
    dc_brake_stop_time_nxt      = dc_brake_stop_time_r;
    lower_output_freq_limit_nxt = lower_output_freq_limit_r;
    min_output_off_time_nxt     = min_output_off_time_r;
    decel_time_one_nxt          = decel_time_one_r;
    prdata_nxt                  = prdata_r;
    pslverr_nxt                 = pslverr_r;
    if (wr_en) begin
      case (paddr)
        run_stop_pkg::CTRL_OFS: begin
          run_source_select_nxt  = pwdata[run_stop_pkg::SRC_LSB +: 2];
          stop_method_select_nxt = pwdata[run_stop_pkg::STOP_LSB +: 2];
        end
        run_stop_pkg::MFI_OFS: mfi_nxt = pwdata[29:0];
        run_stop_pkg::INIT_OFS: begin
          // three-wire init value puts direction on the fifth terminal
          if (pwdata[15:0] == run_stop_pkg::INIT_3WIRE) begin
            mfi_nxt = run_stop_pkg::MFI_3WIRE;
          end
        end
        run_stop_pkg::BRAKE_OFS: begin
          zero_speed_level_nxt = (pwdata[7:0] > run_stop_pkg::ZSPD_MAX)
                               ? run_stop_pkg::ZSPD_MAX : pwdata[7:0];
          dc_brake_current_nxt = (pwdata[run_stop_pkg::CUR_LSB +: 7] > run_stop_pkg::CUR_MAX)
                               ? run_stop_pkg::CUR_MAX
                               : pwdata[run_stop_pkg::CUR_LSB +: 7];
          dc_brake_stop_time_nxt =
            (pwdata[run_stop_pkg::BTIME_LSB +: 10] > run_stop_pkg::BTIME_MAX)
            ? run_stop_pkg::BTIME_MAX : pwdata[run_stop_pkg::BTIME_LSB +: 10];
        end
        run_stop_pkg::LIMIT_OFS: lower_output_freq_limit_nxt = pwdata[15:0];
        run_stop_pkg::TIMES_OFS: begin
          min_output_off_time_nxt = pwdata[run_stop_pkg::OFF_LSB +: 8];
          decel_time_one_nxt      = pwdata[run_stop_pkg::DECEL_LSB +: 16];
        end
        default: ;                                          // status is read-only
      endcase
    end
    if (setup) begin
      pslverr_nxt = ~mapped;
      case (paddr)
        run_stop_pkg::CTRL_OFS:   prdata_nxt = {28'h0000000, stop_method_select_r,
                                                run_source_select_r};
        run_stop_pkg::MFI_OFS:    prdata_nxt = {2'h0, mfi_r};
        run_stop_pkg::BRAKE_OFS:  prdata_nxt = {6'h00, dc_brake_stop_time_r, 1'b0,
                                                dc_brake_current_r, zero_speed_level_r};
        run_stop_pkg::LIMIT_OFS:  prdata_nxt = {16'h0000, lower_output_freq_limit_r};
        run_stop_pkg::TIMES_OFS:  prdata_nxt = {decel_time_one_r, 8'h00,
                                                min_output_off_time_r};
        run_stop_pkg::STATUS_OFS: prdata_nxt = {timer_r, 6'h00, three_wire, rev_cmd,
                                                run_cmd, state_r};
        default:                  prdata_nxt = 32'h00000000;  // init reads zero
      endcase
    end
  end

  // register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_source_select_r       <= run_stop_pkg::SRC_RST;
      stop_method_select_r      <= run_stop_pkg::STOP_RST;
      mfi_r                     <= run_stop_pkg::MFI_RST;
      zero_speed_level_r        <= run_stop_pkg::ZSPD_RST;
      dc_brake_current_r        <= run_stop_pkg::CUR_RST;
      dc_brake_stop_time_r      <= run_stop_pkg::BTIME_RST;
      lower_output_freq_limit_r <= run_stop_pkg::LIMIT_RST;
      min_output_off_time_r     <= run_stop_pkg::OFF_RST;
      decel_time_one_r          <= run_stop_pkg::DECEL_RST;
      prdata_r                  <= 32'h00000000;
      pslverr_r                 <= 1'b0;
    end else begin
      run_source_select_r       <= run_source_select_nxt;
      stop_method_select_r      <= stop_method_select_nxt;
      mfi_r                     <= mfi_nxt;
      zero_speed_level_r        <= zero_speed_level_nxt;
      dc_brake_current_r        <= dc_brake_current_nxt;
      dc_brake_stop_time_r      <= dc_brake_stop_time_nxt;
      lower_output_freq_limit_r <= lower_output_freq_limit_nxt;
      min_output_off_time_r     <= min_output_off_time_nxt;
      decel_time_one_r          <= decel_time_one_nxt;
      prdata_r                  <= prdata_nxt;
      pslverr_r                 <= pslverr_nxt;
    end
  end

  // run command decode from the selected source
  always_comb begin
    // panel: stop key beats run key, jog runs while held
    panel_run_nxt = panel.stop ? 1'b0 : (panel.run ? 1'b1 : panel_run_r);
    panel_rev_nxt = panel.fwd_rev ? ~panel_rev_r : panel_rev_r;
    // three-wire: stop terminal open drops the hold, a run pulse sets it
    // (the outside holds the run pulse 50 ms; any sampled cycle latches)
    if (!three_wire || !term_in[2]) begin
      wire3_run_nxt = 1'b0;
    end else if (term_in[0]) begin
      wire3_run_nxt = 1'b1;
    end else begin
      wire3_run_nxt = wire3_run_r;
    end
    case (run_stop_pkg::run_src_t'(run_source_select_r))
      run_stop_pkg::SRC_PANEL: begin
        run_cmd = panel_run_r | panel.jog;
        rev_cmd = panel_rev_r;
      end
      run_stop_pkg::SRC_TERM: begin
        if (three_wire) begin
          run_cmd = wire3_run_r;
          rev_cmd = |dir_hit;
        end else begin
          run_cmd = term_in[0] ^ term_in[1];
          rev_cmd = term_in[1] & ~term_in[0];
        end
      end
      run_stop_pkg::SRC_COMM: begin
        run_cmd = comm_cmd.run;
        rev_cmd = comm_cmd.rev;
      end
      default: begin
        run_cmd = opt_cmd.run;
        rev_cmd = opt_cmd.rev;
      end
    endcase
  end

  // sequencer next state: run, stop methods, braking and lockouts
  always_comb begin
    state_nxt    = state_r;
    dir_nxt      = dir_r;
    tick_cnt_nxt = tick ? 20'h00000 : tick_cnt_r + 20'h00001;
    timer_nxt    = (tick && timer_r != 20'h00000) ? timer_r - 20'h00001 : timer_r;
    case (state_r)
      run_stop_pkg::ST_IDLE: begin
        if (run_cmd) begin
          state_nxt = run_stop_pkg::ST_RUN;
          dir_nxt   = rev_cmd;
        end
      end
      run_stop_pkg::ST_RUN: begin
        dir_nxt = rev_cmd;
        if (!run_cmd) begin
          case (run_stop_pkg::stop_mode_t'(stop_method_select_r))
            run_stop_pkg::STOP_DECEL: state_nxt = run_stop_pkg::ST_DECEL;
            run_stop_pkg::STOP_COAST: begin
              state_nxt = run_stop_pkg::ST_LOCK;
              timer_nxt = off_ticks;
            end
            run_stop_pkg::STOP_DCB: begin
              state_nxt = run_stop_pkg::ST_BBWAIT;
              timer_nxt = off_ticks;
            end
            default: begin
              state_nxt = run_stop_pkg::ST_LOCK;
              timer_nxt = decel_ticks;
            end
          endcase
        end
      end
      run_stop_pkg::ST_DECEL: begin
        if (run_cmd) begin
          state_nxt = run_stop_pkg::ST_RUN;
        end else if (out_freq < start_freq) begin
          if (brake_ticks == 20'h00000) begin
            state_nxt = run_stop_pkg::ST_IDLE;
          end else begin
            state_nxt = run_stop_pkg::ST_BRAKE;
            timer_nxt = brake_ticks;
          end
        end
      end
      run_stop_pkg::ST_BRAKE: begin
        if (run_cmd) begin
          state_nxt = run_stop_pkg::ST_RUN;                // a run cancels braking
          dir_nxt   = rev_cmd;
        end else if (timer_r == 20'h00000) begin
          state_nxt = run_stop_pkg::ST_IDLE;
        end
      end
      run_stop_pkg::ST_BBWAIT: begin
        // output off for the baseblock time, then dc brake to rest
        if (timer_r == 20'h00000) begin
          if (brake_ticks == 20'h00000) begin
            state_nxt = run_stop_pkg::ST_IDLE;
          end else begin
            state_nxt = run_stop_pkg::ST_BRAKE;
            timer_nxt = brake_ticks;
          end
        end
      end
      run_stop_pkg::ST_LOCK: begin
        // run commands are ignored until the timer runs out
        if (timer_r == 20'h00000) begin
          state_nxt = run_stop_pkg::ST_IDLE;
        end
      end
      default: state_nxt = run_stop_pkg::ST_IDLE;
    endcase
    // power stage commands follow the next state
    drive_nxt.output_on     = (state_nxt == run_stop_pkg::ST_RUN)
                           || (state_nxt == run_stop_pkg::ST_DECEL);
    drive_nxt.reverse       = dir_nxt;
    drive_nxt.decel_req     = (state_nxt == run_stop_pkg::ST_DECEL);
    drive_nxt.dc_brake      = (state_nxt == run_stop_pkg::ST_BRAKE);
    drive_nxt.brake_current = dc_brake_current_r;
  end

  // sequencer and decode flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= run_stop_pkg::ST_IDLE;
      timer_r     <= 20'h00000;
      tick_cnt_r  <= 20'h00000;
      dir_r       <= 1'b0;
      drive_r     <= '0;
      panel_run_r <= 1'b0;
      panel_rev_r <= 1'b0;
      wire3_run_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      timer_r     <= timer_nxt;
      tick_cnt_r  <= tick_cnt_nxt;
      dir_r       <= dir_nxt;
      drive_r     <= drive_nxt;
      panel_run_r <= panel_run_nxt;
      panel_rev_r <= panel_rev_nxt;
      wire3_run_r <= wire3_run_nxt;
    end
  end

  // checks on the sequencer
  src_comm_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_source_select_r == 2'h2 |-> run_cmd == comm_cmd.run)
    else $error("serial link run command not followed");
  panel_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_source_select_r == 2'h0 && panel.run && !panel.stop |=> run_cmd)
    else $error("panel run key not latched");
  two_wire_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_source_select_r == 2'h1 && !three_wire && term_in[1:0] == 2'h1
      |-> run_cmd && !rev_cmd)
    else $error("two-wire forward decode wrong");
  wire3_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    three_wire && wire3_run_r && term_in[2] ##1 three_wire && term_in[2] |-> wire3_run_r)
    else $error("three-wire run hold dropped without stop");
  decel_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == run_stop_pkg::ST_RUN && !run_cmd && stop_method_select_r == 2'h0
      |=> drive.decel_req && drive.output_on)
    else $error("deceleration not started on stop");
  brake_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == run_stop_pkg::ST_DECEL && !run_cmd && out_freq < start_freq
      && dc_brake_stop_time_r != 10'h000 |=> drive.dc_brake && timer_r == $past(brake_ticks))
    else $error("dc brake not applied below zero speed");
  brake_floor_a: assert property (@(posedge pclk) disable iff (!presetn)
    {8'h00, zero_speed_level_r} < lower_output_freq_limit_r |-> start_freq == lower_output_freq_limit_r)
    else $error("brake start ignores lower limit");
  brake_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == run_stop_pkg::ST_DECEL && !run_cmd && out_freq < start_freq
      && dc_brake_stop_time_r == 10'h000 |=> state_r == run_stop_pkg::ST_IDLE && !drive.dc_brake)
    else $error("zero brake time still brakes");
  coast_cut_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == run_stop_pkg::ST_RUN && !run_cmd && stop_method_select_r == 2'h1
      |=> !drive.output_on && state_r == run_stop_pkg::ST_LOCK)
    else $error("coast stop did not cut output");
  lock_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == run_stop_pkg::ST_LOCK && timer_r != 20'h00000 |=> state_r == run_stop_pkg::ST_LOCK)
    else $error("run accepted during lockout");
  timer_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == run_stop_pkg::ST_RUN && !run_cmd && stop_method_select_r == 2'h3
      |=> !drive.output_on && timer_r == $past(decel_ticks))
    else $error("timed coast lockout not loaded");

endmodule

// ===== tb/run_stop_far_side.sv
// far-side model: run, stop and direction switch contacts wired to the terminals
module run_stop_far_side (
  input  wire logic [3:0] press,
  output logic      [6:0] term_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // press is {direction, stop, second run, first run}; open contacts read low
  // the stop switch is normally closed, so pressing it opens the third terminal
  always_comb begin
    term_in = {2'h0, press[3], 1'b0, ~press[2], press[1:0]};
  end
endmodule

// ===== tb/run_stop_sequencer_bench.sv
// bench for the run/stop sequencer: apb access, two-wire run, coast lock, decel brake
module run_stop_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]                paddr;
  logic [31:0]               pwdata, prdata, rd, seed;
  logic [3:0]                press;
  logic [6:0]                term_in;
  logic [15:0]               out_freq;
  logic [6:0]                cur;
  run_stop_pkg::panel_keys_t panel;
  run_stop_pkg::ext_cmd_t    comm_cmd, opt_cmd;
  run_stop_pkg::drive_out_t  drive;
  int                        num_errors = 0, tests_run = 0, cycles = 0;
  // device with short 2-clock ticks so the timers finish quickly
  run_stop_sequencer #(.TICK_CYCLES(2)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .term_in(term_in), .panel(panel),
    .comm_cmd(comm_cmd), .opt_cmd(opt_cmd), .out_freq(out_freq), .drive(drive));
  run_stop_far_side u_far (.press(press), .term_in(term_in));
  // free-running 50 mhz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      summarize();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic summarize();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // wait, then compare {output_on, reverse, decel_req, dc_brake}
  task automatic dchk(input int n, input logic [3:0] exp);
    repeat (n) @(posedge pclk);
    check("drive", {28'h0, exp}, {28'h0, drive[10:7]});
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, press, panel, comm_cmd, opt_cmd} = '0;
    out_freq = 16'h0300;
    seed = xs(32'h72F3BA08);
    cur = 7'(seed % 101);
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, run_stop_pkg::BRAKE_OFS, 32'h0);
    check("brake", 32'h0032_3205, rd);
    apb(1'b0, run_stop_pkg::CTRL_OFS, 32'h0);
    check("ctrl", 32'h0000_0001, rd);
    apb(1'b0, run_stop_pkg::MFI_OFS, 32'h0);
    check("mfi", 32'h0614_40C1, rd);
    apb(1'b0, 8'h40, 32'h0);
    check("pslverr", 32'h1, {31'h0, err});
    apb(1'b1, run_stop_pkg::BRAKE_OFS, {16'h0032, 1'b0, cur, 8'h05});
    apb(1'b1, run_stop_pkg::CTRL_OFS, 32'h0000_0005);
    press <= 4'h2;
    dchk(3, 4'b1100);
    press <= 4'h0;
    dchk(3, 4'b0000);
    press <= 4'h1;
    dchk(3, 4'b0000);
    dchk(120, 4'b1000);
    apb(1'b1, run_stop_pkg::CTRL_OFS, 32'h0000_0001);
    press <= 4'h0;
    dchk(3, 4'b1010);
    out_freq <= 16'h0004;
    dchk(3, 4'b0001);
    check("current", {25'h0, cur}, {25'h0, drive.brake_current});
    dchk(110, 4'b0000);
    apb(1'b1, run_stop_pkg::CTRL_OFS, 32'h0000_0002);
    press <= 4'h1;
    dchk(3, 4'b0000);
    comm_cmd <= 2'b11;
    dchk(3, 4'b1100);
    // timed coast from the serial link: run ignored for the short decel time
    apb(1'b1, run_stop_pkg::TIMES_OFS, 32'h0003_0005);
    apb(1'b1, run_stop_pkg::CTRL_OFS, 32'h0000_000E);
    comm_cmd <= 2'b00;
    press <= 4'h0;
    dchk(2, 4'b0000);
    comm_cmd <= 2'b10;
    dchk(3, 4'b0000);
    dchk(80, 4'b1000);
    // dc braking stop on switching to the idle panel: baseblock wait, then brake
    apb(1'b1, run_stop_pkg::CTRL_OFS, 32'h0000_0008);
    dchk(3, 4'b0000);
    dchk(105, 4'b0001);
    dchk(100, 4'b0000);
    // panel run key latches; panel stop key with zero brake time and a raised floor
    panel <= 4'h8;
    @(posedge pclk);
    panel <= 4'h0;
    dchk(2, 4'b1000);
    apb(1'b1, run_stop_pkg::BRAKE_OFS, {16'h0000, 1'b0, cur, 8'h05});
    apb(1'b1, run_stop_pkg::LIMIT_OFS, 32'h0000_0008);
    apb(1'b1, run_stop_pkg::CTRL_OFS, 32'h0000_0000);
    out_freq <= 16'h0006;
    panel <= 4'h4;
    @(posedge pclk);
    panel <= 4'h0;
    dchk(3, 4'b0000);
    // three-wire init: fifth terminal gives direction, run pulse self-holds
    apb(1'b1, run_stop_pkg::INIT_OFS, 32'h0000_0D02);
    apb(1'b0, run_stop_pkg::MFI_OFS, 32'h0);
    check("mfi", 32'h0614_00C1, rd);
    apb(1'b1, run_stop_pkg::CTRL_OFS, 32'h0000_0001);
    press <= 4'h9;
    repeat (10) @(posedge pclk);
    press <= 4'h8;
    dchk(3, 4'b1100);
    press <= 4'hC;
    dchk(4, 4'b0100);
    summarize();
  end
endmodule
